// [core/pmrv_pkg.sv]
// ****************************************************************
// Constants shared by the register view and its sampling stage.
// ****************************************************************
package pmrv_pkg;

  // ****************************************************************
  // Register offsets on the plain register port.
  // ****************************************************************
  localparam logic [7:0]  OFS_P2_CTRL    = 8'h00;  // Port 2 control.
  localparam logic [7:0]  OFS_P2_STATUS  = 8'h02;  // Port 2 status.
  localparam logic [7:0]  OFS_P2_ID_LOW  = 8'h04;  // Port 2 id low.
  localparam logic [7:0]  OFS_P1_ABILITY = 8'h0a;  // Port 1 partner.

  // ****************************************************************
  // Port 2 control field positions.
  // ****************************************************************
  localparam int CTL_LOOPBACK    = 14;  // Far-end loopback.
  localparam int CTL_SPEED_100   = 13;  // Forced speed, 1 is 100.
  localparam int CTL_NEG_ENABLE  = 12;  // Auto-negotiation enable.
  localparam int CTL_POWER_DOWN  = 11;  // Power down.
  localparam int CTL_NEG_RESTART = 9;   // Restart negotiation.
  localparam int CTL_FULL_DUPLEX = 8;   // Forced duplex, 1 is full.
  localparam int CTL_XOVER_ALG   = 5;   // Crossover algorithm select.
  localparam int CTL_FORCE_CROSS = 4;   // Force crossed pairs.
  localparam int CTL_XOVER_OFF   = 3;   // Disable auto crossover.
  localparam int CTL_SPARE       = 2;   // Writable spare bit.
  localparam int CTL_TX_DISABLE  = 1;   // Transmitter off.
  localparam int CTL_LED_DISABLE = 0;   // Indicator off.

  // Reset value and the bits that are stored on a write.
  localparam logic [15:0] CTL_RESET      = 16'h1020;
  localparam logic [15:0] CTL_WRITE_MASK = 16'h793f;

  // ****************************************************************
  // Port 2 status fields.
  // ****************************************************************
  localparam logic [15:0] STS_FIXED      = 16'h7808;  // Ability bits.
  localparam int          STS_NEG_DONE   = 5;         // Negotiated.
  localparam int          STS_LINK_UP    = 2;         // Link up.

  // ****************************************************************
  // Port 1 partner ability fields.
  // ****************************************************************
  localparam int          ABL_PAUSE      = 10;        // Pause.
  localparam int          ABL_MODE_LSB   = 5;         // 10 half.
  localparam logic [4:0]  ABL_LOW_FIELD  = 5'h01;     // Bits 4 to 0.
  localparam logic [4:0]  ABL_RESET      = 5'h00;     // Sampled bits.
  localparam logic [1:0]  STS_RESET      = 2'h0;      // Sampled bits.

endpackage : pmrv_pkg

// [core/pmrv_sample_reg.sv]
`timescale 1ns/1ps
// ****************************************************************
// Resettable sampling register for line-side status levels.
// ****************************************************************
module pmrv_sample_reg #(
  parameter int         WIDTH = 1,            // Sampled width.
  parameter logic [4:0] RST   = 5'h00         // Reset value, low bits.
) (
  // Clock and reset.
  input  wire logic             clk_in,       // System clock.
  input  wire logic             rstn_in,      // Asynchronous, low.
  // Data.
  input  wire logic [WIDTH-1:0] d_in,         // Level to sample.
  output logic      [WIDTH-1:0] q_out         // Registered level.
);

  // Inputs are synchronous already, so one stage only aligns them.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q_out <= RST[WIDTH-1:0];
    end else begin
      q_out <= d_in;
    end
  end

endmodule : pmrv_sample_reg

// [core/pmrv_top.sv]
`timescale 1ns/1ps
// Function
// - Port 1 partner pause bit, read-only, resets zero.
// - Partner bits 8 to 5 report duplex abilities.
// - Control bit 14 enables far-end loopback.
// - Control bit 12 enables negotiation, resets one.
// - Negotiation off: speed bit 13, duplex bit 8.
// - Writing control bit 9 restarts negotiation.
// - Control bit 5 picks crossover algorithm, resets one.
// - Bit 4 forces crossing, bit 3 disables auto.
// - Control bit 1 silences the transmitter.
// - Status bits 14 to 11 read one.
// - Status bit 15 reads zero.
// - Status bit 0 reads zero.
// - Status bit 5 shows negotiation complete.
// - Status bit 3 reads one.
// - Identifier low register is fixed, read-only.
module pmrv_top #(
  // Arbitrary neutral identifier value.
  parameter logic [15:0] ID_LOW = 16'h5a5a
) (
  // Clock and reset.
  input  wire logic        REF_CLK_IN,           // 50 MHz clock.
  input  wire logic        RSTN_IN,              // Asynchronous, low.
  // Register port.
  input  wire logic [7:0]  REG_ADDR_IN,          // Register offset.
  input  wire logic [15:0] REG_WDATA_IN,         // Write data.
  input  wire logic        REG_WR_IN,            // Write strobe.
  input  wire logic        REG_RD_IN,            // Read strobe.
  output logic      [15:0] REG_RDATA_OUT,        // Read data.
  // Port 1 partner abilities from the negotiation engine.
  input  wire logic        P1_LP_PAUSE_IN,       // Partner pause.
  input  wire logic        P1_LP_100_FULL_IN,    // Partner 100 full.
  input  wire logic        P1_LP_100_HALF_IN,    // Partner 100 half.
  input  wire logic        P1_LP_10_FULL_IN,     // Partner 10 full.
  input  wire logic        P1_LP_10_HALF_IN,     // Partner 10 half.
  // Port 2 line state.
  input  wire logic        P2_NEG_DONE_IN,       // Negotiation done.
  input  wire logic        P2_LINK_UP_IN,        // Link up.
  input  wire logic        P2_NEG_SPEED_100_IN,  // Negotiated speed.
  input  wire logic        P2_NEG_FULL_IN,       // Negotiated duplex.
  // Port 2 controls.
  output logic             P2_LOOPBACK_OUT,      // Far-end loopback.
  output logic             P2_NEG_ENABLE_OUT,    // Negotiation on.
  output logic             P2_NEG_RESTART_OUT,   // Restart pulse.
  output logic             P2_SPEED_100_OUT,     // Operating speed.
  output logic             P2_FULL_DUPLEX_OUT,   // Operating duplex.
  output logic             P2_POWER_DOWN_OUT,    // Power down.
  output logic             P2_XOVER_ALG_OUT,     // Crossover variant.
  output logic             P2_FORCE_CROSS_OUT,   // Force crossed pairs.
  output logic             P2_XOVER_OFF_OUT,     // Auto crossover off.
  output logic             P2_TX_DISABLE_OUT,    // Transmitter off.
  output logic             P2_LED_DISABLE_OUT    // Indicator off.
);

  // ****************************************************************
  // Declarations.
  // ****************************************************************
  logic [15:0] ctrl_reg;      // Stored control bits.
  logic [15:0] ctrl_next;     // Control value after a write.
  logic        restart_reg;   // One-cycle restart request.
  logic        speed_reg;     // Operating speed.
  logic        duplex_reg;    // Operating duplex.
  logic [15:0] rdata_reg;     // Read answer.
  logic [15:0] rdata_next;    // Read answer being formed.
  logic [4:0]  ability_q;     // Sampled partner abilities.
  logic [1:0]  status_q;      // Sampled done and link.
  logic        ctrl_wr;       // Write hits the control register.

  assign ctrl_wr = REG_WR_IN && (REG_ADDR_IN == pmrv_pkg::OFS_P2_CTRL);

  // ****************************************************************
  // Line-side sampling.
  // ****************************************************************
  // Partner abilities, pause on top, then 100 full down to 10 half.
  pmrv_sample_reg #(
    .WIDTH (5),
    .RST   (pmrv_pkg::ABL_RESET)
  ) u_ability (
    .clk_in  (REF_CLK_IN),
    .rstn_in (RSTN_IN),
    .d_in    ({P1_LP_PAUSE_IN, P1_LP_100_FULL_IN, P1_LP_100_HALF_IN,
               P1_LP_10_FULL_IN, P1_LP_10_HALF_IN}),
    .q_out   (ability_q)
  );

  // Negotiation done in bit 1, link in bit 0.
  pmrv_sample_reg #(
    .WIDTH (2),
    .RST   ({3'h0, pmrv_pkg::STS_RESET})
  ) u_status (
    .clk_in  (REF_CLK_IN),
    .rstn_in (RSTN_IN),
    .d_in    ({P2_NEG_DONE_IN, P2_LINK_UP_IN}),
    .q_out   (status_q)
  );

  // ****************************************************************
  // Control register.
  // ****************************************************************
  // Read-only and self-clearing bits are masked off, so they read 0.
  always_comb begin
    ctrl_next = (REG_WDATA_IN & pmrv_pkg::CTL_WRITE_MASK);
  end

  // Stored bits drive the port directly, except speed and duplex (mode stage) and the spare bit.
  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      ctrl_reg <= pmrv_pkg::CTL_RESET;
    end else if (ctrl_wr) begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Restart is a pulse: the bit clears itself so a second write of 1
  // always restarts again, at the cost of never reading back as 1.
  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      restart_reg <= 1'b0;
    end else begin
      restart_reg <= ctrl_wr &&
                     REG_WDATA_IN[pmrv_pkg::CTL_NEG_RESTART];
    end
  end

  // ****************************************************************
  // Operating speed and duplex.
  // ****************************************************************
  // Forced values apply only while negotiation is off.
  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      speed_reg  <= 1'b0;
      duplex_reg <= 1'b0;
    end else if (ctrl_reg[pmrv_pkg::CTL_NEG_ENABLE]) begin
      speed_reg  <= P2_NEG_SPEED_100_IN;
      duplex_reg <= P2_NEG_FULL_IN;
    end else begin
      speed_reg  <= ctrl_reg[pmrv_pkg::CTL_SPEED_100];
      duplex_reg <= ctrl_reg[pmrv_pkg::CTL_FULL_DUPLEX];
    end
  end

  // ****************************************************************
  // Read path.
  // ****************************************************************
  // Unmapped offsets answer zero.
  always_comb begin
    rdata_next = 16'h0000;
    case (REG_ADDR_IN)
      pmrv_pkg::OFS_P2_CTRL: begin
        rdata_next = ctrl_reg;
      end
      pmrv_pkg::OFS_P2_STATUS: begin
        rdata_next = pmrv_pkg::STS_FIXED;
        rdata_next[pmrv_pkg::STS_NEG_DONE] = status_q[1];
        rdata_next[pmrv_pkg::STS_LINK_UP]  = status_q[0];
      end
      pmrv_pkg::OFS_P2_ID_LOW: begin
        rdata_next = ID_LOW;
      end
      pmrv_pkg::OFS_P1_ABILITY: begin
        rdata_next[pmrv_pkg::ABL_PAUSE] = ability_q[4];
        rdata_next[pmrv_pkg::ABL_MODE_LSB +: 4] = ability_q[3:0];
        rdata_next[4:0] = pmrv_pkg::ABL_LOW_FIELD;
      end
      default: begin
        rdata_next = 16'h0000;
      end
    endcase
  end

  // Data stand only in the cycle after the read strobe.
  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      rdata_reg <= 16'h0000;
    end else if (REG_RD_IN) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= 16'h0000;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign REG_RDATA_OUT      = rdata_reg;
  assign P2_LOOPBACK_OUT    = ctrl_reg[pmrv_pkg::CTL_LOOPBACK];
  assign P2_NEG_ENABLE_OUT  = ctrl_reg[pmrv_pkg::CTL_NEG_ENABLE];
  assign P2_NEG_RESTART_OUT = restart_reg;
  assign P2_SPEED_100_OUT   = speed_reg;
  assign P2_FULL_DUPLEX_OUT = duplex_reg;
  assign P2_POWER_DOWN_OUT  = ctrl_reg[pmrv_pkg::CTL_POWER_DOWN];
  assign P2_XOVER_ALG_OUT   = ctrl_reg[pmrv_pkg::CTL_XOVER_ALG];
  assign P2_FORCE_CROSS_OUT = ctrl_reg[pmrv_pkg::CTL_FORCE_CROSS];
  assign P2_XOVER_OFF_OUT   = ctrl_reg[pmrv_pkg::CTL_XOVER_OFF];
  assign P2_TX_DISABLE_OUT  = ctrl_reg[pmrv_pkg::CTL_TX_DISABLE];
  assign P2_LED_DISABLE_OUT = ctrl_reg[pmrv_pkg::CTL_LED_DISABLE];

  // ****************************************************************
  // Checks.
  // ****************************************************************
  // Read strobe on one offset, one sequence for all registers.
  sequence seq_read(logic [7:0] ofs);
    REG_RD_IN && (REG_ADDR_IN == ofs);
  endsequence

  // A control write carrying the restart bit.
  sequence seq_restart_write;
    ctrl_wr && REG_WDATA_IN[pmrv_pkg::CTL_NEG_RESTART];
  endsequence

  // Exactly one cycle of restart, then quiet unless written again.
  sequence seq_one_pulse;
    P2_NEG_RESTART_OUT ##1 (!P2_NEG_RESTART_OUT || $past(ctrl_wr));
  endsequence

  chk_ability_pause: assert property (
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    seq_read(pmrv_pkg::OFS_P1_ABILITY) |=>
      REG_RDATA_OUT[10] == $past(ability_q[4]))
    else $error("Partner pause bit wrong.");

  chk_ability_modes: assert property (
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    seq_read(pmrv_pkg::OFS_P1_ABILITY) |=>
      REG_RDATA_OUT[8:5] == $past(ability_q[3:0]))
    else $error("Partner mode bits wrong.");

  chk_loopback_write: assert property (
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    ctrl_wr |=> P2_LOOPBACK_OUT == $past(REG_WDATA_IN[14]))
    else $error("Loopback does not follow write.");

  chk_neg_enable: assert property (
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    ctrl_wr |=> P2_NEG_ENABLE_OUT == $past(REG_WDATA_IN[12]))
    else $error("Negotiation enable does not follow write.");

  chk_forced_mode: assert property (
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    !P2_NEG_ENABLE_OUT |=> (P2_SPEED_100_OUT == $past(ctrl_reg[13]))
      && (P2_FULL_DUPLEX_OUT == $past(ctrl_reg[8])))
    else $error("Forced speed or duplex not applied.");

  chk_restart_pulse: assert property (
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    seq_restart_write |=> seq_one_pulse)
    else $error("Restart is not a single pulse.");

  chk_xover_bits: assert property (
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    ctrl_wr |=> (P2_XOVER_ALG_OUT == $past(REG_WDATA_IN[5]))
      && (P2_FORCE_CROSS_OUT == $past(REG_WDATA_IN[4]))
      && (P2_XOVER_OFF_OUT == $past(REG_WDATA_IN[3])))
    else $error("Crossover controls do not follow write.");

  chk_tx_power: assert property (
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    ctrl_wr |=> (P2_TX_DISABLE_OUT == $past(REG_WDATA_IN[1]))
      && (P2_POWER_DOWN_OUT == $past(REG_WDATA_IN[11])))
    else $error("Transmit or power control wrong.");

  chk_status_fixed: assert property (
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    seq_read(pmrv_pkg::OFS_P2_STATUS) |=>
      (REG_RDATA_OUT[15:11] == 5'h0f) && REG_RDATA_OUT[3]
      && !REG_RDATA_OUT[0])
    else $error("Fixed status bits wrong.");

  chk_status_live: assert property (
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    seq_read(pmrv_pkg::OFS_P2_STATUS) |=>
      (REG_RDATA_OUT[5] == $past(status_q[1]))
      && (REG_RDATA_OUT[2] == $past(status_q[0])))
    else $error("Done or link bit wrong.");

  chk_id_value: assert property (
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    seq_read(pmrv_pkg::OFS_P2_ID_LOW) |=> REG_RDATA_OUT == ID_LOW)
    else $error("Identifier low wrong.");

  // While negotiation runs, the negotiated mode is followed one cycle
  // late, so a forced setting left in the register has no effect.
  chk_neg_mode: assert property (
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    P2_NEG_ENABLE_OUT |=> (P2_SPEED_100_OUT == $past(P2_NEG_SPEED_100_IN))
      && (P2_FULL_DUPLEX_OUT == $past(P2_NEG_FULL_IN)))
    else $error("Negotiated speed or duplex not applied.");

  // A control read shows the stored word; restart never reads back.
  chk_ctrl_readback: assert property (
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    seq_read(pmrv_pkg::OFS_P2_CTRL) |=>
      (REG_RDATA_OUT == $past(ctrl_reg)) && !REG_RDATA_OUT[9])
    else $error("Control read back wrong.");

  // Without a control write the restart output stays quiet.
  chk_restart_idle: assert property (
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    !ctrl_wr |=> !P2_NEG_RESTART_OUT)
    else $error("Restart pulse without a write.");

endmodule : pmrv_top

// [dv/pmrv_link_partner.sv]
`timescale 1ns/1ps
// ****************************************************************
// Behavioural link partner across the cable.
// ****************************************************************
module pmrv_link_partner #(
  parameter int NEG_CYCLES = 40     // Cycles one negotiation takes.
) (
  // Clock and reset.
  input  wire logic       clk_in,       // System clock.
  input  wire logic       rstn_in,      // Asynchronous, low.
  // Abilities offered, {pause, 100 full, 100 half, 10 full, 10 half}.
  input  wire logic [4:0] adv_in,       // Chosen by the bench.
  // Local controls that take the line down.
  input  wire logic       restart_in,   // Restart pulse.
  input  wire logic       quiet_in,     // Powered down or silent.
  // Line state handed to the register view.
  output logic      [4:0] ability_out,  // Learned partner abilities.
  output logic            done_out,     // Negotiated, link up.
  output logic            link_out,     // Line up.
  output logic            speed_out,    // Negotiated 100.
  output logic            full_out      // Negotiated full duplex.
);
  int unsigned cnt;  // Cycles spent negotiating.

  // A restart or a silent local side drops the link at once, so the
  // bench can see the status bits fall as well as rise.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt      <= 0;
      done_out <= 1'b0;
    end else if (restart_in || quiet_in) begin
      cnt      <= 0;
      done_out <= 1'b0;
    end else if (cnt < NEG_CYCLES) begin
      cnt <= cnt + 1;
    end else begin
      done_out <= 1'b1;
    end
  end

  // Line energy is seen half way through the exchange, so the link bit
  // rises before the done bit and the two can be told apart.
  assign link_out = done_out || (cnt >= NEG_CYCLES / 2);

  // Abilities are only known once the exchange has finished.
  assign ability_out = done_out ? adv_in : 5'h00;
  // Best common mode: any 100 ability wins, then full over half.
  assign speed_out   = |adv_in[3:2];
  assign full_out    = speed_out ? adv_in[3] : adv_in[1];

endmodule : pmrv_link_partner

// [dv/testbench.sv]
`timescale 1ns/1ps
// ****************************************************************
// Self-checking bench for the port register view.
// ****************************************************************
module testbench;
  localparam int          NEG = 40;        // Partner negotiation time.
  localparam logic [15:0] ID  = 16'h3c3c;  // Arbitrary identifier.

  logic        REF_CLK_IN, RSTN_IN, REG_WR_IN, REG_RD_IN;  // Bus and clock.
  logic [7:0]  REG_ADDR_IN;                 // Register offset.
  logic [15:0] REG_WDATA_IN, REG_RDATA_OUT; // Data both ways.
  logic [4:0]  adv, abl;                    // Offered and learned.
  logic        done, link, n_spd, n_ful;    // Partner line state.
  logic [10:0] o;                           // All control outputs.
  logic        rd_pend;                     // Read answer due now.
  logic [15:0] exp_q[$];                    // Expected read data.
  int          errors, checks, cycles;      // Report counters.

  pmrv_top #(.ID_LOW(ID)) dut (
    .REF_CLK_IN(REF_CLK_IN), .RSTN_IN(RSTN_IN), .REG_ADDR_IN(REG_ADDR_IN),
    .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN),
    .REG_RD_IN(REG_RD_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
    .P1_LP_PAUSE_IN(abl[4]), .P1_LP_100_FULL_IN(abl[3]),
    .P1_LP_100_HALF_IN(abl[2]), .P1_LP_10_FULL_IN(abl[1]),
    .P1_LP_10_HALF_IN(abl[0]), .P2_NEG_DONE_IN(done),
    .P2_LINK_UP_IN(link), .P2_NEG_SPEED_100_IN(n_spd),
    .P2_NEG_FULL_IN(n_ful), .P2_LOOPBACK_OUT(o[10]),
    .P2_NEG_ENABLE_OUT(o[9]), .P2_NEG_RESTART_OUT(o[8]),
    .P2_SPEED_100_OUT(o[7]), .P2_FULL_DUPLEX_OUT(o[6]),
    .P2_POWER_DOWN_OUT(o[5]), .P2_XOVER_ALG_OUT(o[4]),
    .P2_FORCE_CROSS_OUT(o[3]), .P2_XOVER_OFF_OUT(o[2]),
    .P2_TX_DISABLE_OUT(o[1]), .P2_LED_DISABLE_OUT(o[0]));

  pmrv_link_partner #(.NEG_CYCLES(NEG)) partner (
    .clk_in(REF_CLK_IN), .rstn_in(RSTN_IN), .adv_in(adv),
    .restart_in(o[8]), .quiet_in(o[5] | o[1]), .ability_out(abl),
    .done_out(done), .link_out(link), .speed_out(n_spd),
    .full_out(n_ful));

  // ****************************************************************
  // Tasks.
  // ****************************************************************
  // Expected control outputs for a stored control word.
  function automatic logic [10:0] ctl_exp(input logic [15:0] c);
    ctl_exp = {c[14], c[12], 1'b0, c[12] ? n_spd : c[13],
               c[12] ? n_ful : c[8], c[11], c[5], c[4], c[3], c[1], c[0]};
  endfunction : ctl_exp

  task automatic check(input string name, input logic [15:0] e,
                       input logic [15:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, e, g);
    end
  endtask : check

  // One bus cycle; every strobe is assigned once per cycle, so calls
  // may follow each other with no gap.
  task automatic bus(input logic w, input logic r, input logic [7:0] a,
                     input logic [15:0] d);
    REG_WR_IN    <= w;
    REG_RD_IN    <= r;
    REG_ADDR_IN  <= a;
    REG_WDATA_IN <= d;
    @(posedge REF_CLK_IN);
  endtask : bus

  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 8'h00, 16'h0000);
  endtask : idle

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, 16'h0000);
  endtask : rd

  // Control write, then a read back. Outputs are looked at one edge
  // after they launch, before that edge's updates: the restart pulse
  // first, the other outputs one edge later once speed has followed.
  task automatic wrc(input logic [15:0] v);
    bus(1'b1, 1'b0, 8'h00, v);
    idle(1);
    check("restart", {15'h0000, v[9]}, {15'h0000, o[8]});
    rd(8'h00, v & 16'h793f);
    check("controls", {5'h00, ctl_exp(v)}, {5'h00, o});
  endtask : wrc

  task automatic stop_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test

  // ****************************************************************
  // Clock, watchdog and read monitor.
  // ****************************************************************
  initial begin
    REF_CLK_IN = 1'b0;
    forever #10 REF_CLK_IN = ~REF_CLK_IN;
  end

  // A hang counts as a mismatch and still reaches the report.
  always @(posedge REF_CLK_IN) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      stop_test();
    end
  end

  // Read data stand only in the cycle after the strobe, else zero.
  always @(posedge REF_CLK_IN) begin
    if (rd_pend) check("read data", exp_q.pop_front(), REG_RDATA_OUT);
    else if (RSTN_IN) check("idle data", 16'h0000, REG_RDATA_OUT);
    rd_pend <= REG_RD_IN;
  end

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    RSTN_IN      = 1'b0;
    REG_WR_IN    = 1'b0;
    REG_RD_IN    = 1'b0;
    REG_ADDR_IN  = 8'h00;
    REG_WDATA_IN = 16'h0000;
    adv          = 5'h00;
    void'($urandom(32'h0b58dcfe));
    repeat (4) @(posedge REF_CLK_IN);
    RSTN_IN <= 1'b1;
    check("reset outputs", {5'h00, ctl_exp(16'h1020)}, {5'h00, o});
    rd(8'h00, 16'h1020);
    rd(8'h02, 16'h7808);
    rd(8'h04, ID);
    rd(8'h0a, 16'h0001);
    rd(8'h06, 16'h0000);
    // Writes to read-only places must leave them untouched.
    bus(1'b1, 1'b0, 8'h02, 16'($urandom));
    bus(1'b1, 1'b0, 8'h04, 16'($urandom));
    bus(1'b1, 1'b0, 8'h0a, 16'($urandom));
    rd(8'h02, 16'h7808);
    rd(8'h04, ID);
    rd(8'h0a, 16'h0001);
    // Every bit alone, then random words, forced and negotiated.
    for (int i = 0; i < 24; i++) begin
      wrc(i < 16 ? 16'h0001 << i : 16'($urandom));
    end
    // Power down, negotiate with a random partner, then restart.
    for (int k = 0; k < 3; k++) begin
      wrc(16'h0820);
      adv <= 5'($urandom);
      idle(2);
      rd(8'h02, 16'h7808);
      wrc(16'h1020);
      idle(NEG / 2 + 8);
      rd(8'h02, 16'h780c);
      idle(NEG / 2 - 5);
      rd(8'h02, 16'h782c);
      rd(8'h0a, {5'h00, adv[4], 1'b0, adv[3:0], 5'h01});
      wrc(16'h1220);
      idle(2);
      rd(8'h02, 16'h7808);
    end
    // A second reset in mid-run restores the defaults.
    idle(1);
    RSTN_IN <= 1'b0;
    idle(2);
    RSTN_IN <= 1'b1;
    rd(8'h00, 16'h1020);
    rd(8'h02, 16'h7808);
    idle(2);
    stop_test();
  end

endmodule : testbench
